// *** rtl/hbc_break.sv ***
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
// Operation
// - mode field: 00 off, 01 dual swi, 10 full debug, 11 dual debug
// - no breakpoint match while background debug is active
// - only dual swi mode raises software interrupt; fetch-tagged breaks only
// - dual swi mode ignores both direction compare bits
// - in dual modes second pair enable gates second address breakpoint
// - size select has no effect in dual modes
// - debug entry only when debug logic enable is asserted
// - dual debug breakpoints qualified by program-only, range and direction bits
// - program-only 0 breaks next boundary; 1 tags fetch to execute
// - program-only: data and unexecuted opcodes never break; meaningless in swi
// - breakpoint 0 compares high byte, or full address with range bit
// - breakpoint 1 in dual modes compares high or full address likewise
// - second pair enable 0 removes second pair from all comparisons
// - full mode high mask 0 compares data 15:8, 1 excludes them
// - full mode low mask 0 compares data 7:0, 1 excludes them
// - second direction enable only qualifies dual second address
// - full mode: pair 1 address, pair 2 data; dual: both addresses
// - both control registers always read/write; control 1 top bit reads zero
// - first breakpoint direction enable 0 don't care; value 0 write, 1 read
// - second dual breakpoint direction value 0 write, 1 read
// - high address compare byte checks address bus high byte
// - tagged fetch proceeds through queue; debug entry at queue head
module hbc_break (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [hbc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [hbc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire hbc_pkg::hbc_cpu_t cpu,
    input wire logic debug_enable,
    input wire logic debug_active,
    output hbc_pkg::hbc_brk_t brk
);
    import hbc_pkg::*;

    typedef struct packed {
        hbc_ctl0_t ctl0;
        hbc_ctl1_t ctl1;
        logic [7:0] addr_compare_high;
        logic [7:0] addr_compare_low;
        logic [7:0] second_compare_high;
        logic [7:0] second_compare_low;
        logic aw_held;
        logic [ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [7:0] w_byte;
        logic w_lane0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        hbc_brk_t brk;
        logic [1:0] hit_seen;
    } hbc_state_t;

    hbc_state_t st;
    hbc_state_t next_st;

    // byte-wise compare: the low byte takes part only when asked
    function automatic logic addr_hit(input logic [7:0] hi, input logic [7:0] lo,
                                      input logic use_lo, input logic [15:0] a);
        addr_hit = (a[15:8] == hi) && (!use_lo || a[7:0] == lo);
    endfunction

    function automatic logic dir_ok(input logic en, input logic val, input logic rd);
        dir_ok = !en || (val == rd);
    endfunction

    // each register owns one aligned word; the word number is its index
    function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        is_reg = (a[ADDR_W-1:2] == idx[ADDR_W-3:0]);
    endfunction

    function automatic logic map_ok(input logic [ADDR_W-1:0] a);
        map_ok = is_reg(a, OFF_CTL0) || is_reg(a, OFF_CTL1)
              || is_reg(a, OFF_ADDR_HI) || is_reg(a, OFF_ADDR_LO)
              || is_reg(a, OFF_SEC_HI) || is_reg(a, OFF_SEC_LO)
              || is_reg(a, OFF_STATUS);
    endfunction

    logic dual;
    logic bp0_raw;
    logic bp1_raw;
    logic full_raw;
    logic hit0;
    logic hit1;
    logic any_hit;
    logic tag_path;
    logic [7:0] wsel_addr;
    logic [7:0] rsel_addr;
    logic [31:0] rword;
    logic [7:0] rbyte;

    always_comb begin
        dual = st.ctl0.mode_sel[0];
        bp0_raw = addr_hit(st.addr_compare_high, st.addr_compare_low,
                           st.ctl0.bp0_low_addr_en, cpu.addr);
        bp1_raw = st.ctl1.second_pair_enable
               && addr_hit(st.second_compare_high, st.second_compare_low,
                           st.ctl0.bp1_low_addr_en, cpu.addr);
        full_raw = bp0_raw
                && dir_ok(st.ctl1.bp0_dir_compare_en, st.ctl1.bp0_dir_value, cpu.rd)
                && (!st.ctl1.second_pair_enable
                    || ((st.ctl1.data_high_mask
                         || cpu.data[15:8] == st.second_compare_high)
                        && (st.ctl1.data_low_mask
                            || cpu.data[7:0] == st.second_compare_low)));
        hit0 = 1'b0;
        hit1 = 1'b0;
        tag_path = st.ctl0.program_only_break;
        unique case (st.ctl0.mode_sel)
            MODE_OFF: begin
                tag_path = 1'b0;
            end
            MODE_SWI_DUAL: begin
                // direction bits ignored, always a fetch tag
                hit0 = bp0_raw;
                hit1 = bp1_raw;
                tag_path = 1'b1;
            end
            MODE_FULL: begin
                hit0 = full_raw;
            end
            MODE_DBG_DUAL: begin
                hit0 = bp0_raw
                    && dir_ok(st.ctl1.bp0_dir_compare_en, st.ctl1.bp0_dir_value,
                              cpu.rd);
                hit1 = bp1_raw
                    && dir_ok(st.ctl1.bp1_dir_compare_en, st.ctl1.bp1_dir_value,
                              cpu.rd);
            end
        endcase
        // program-only breaks fire on opcode fetches only
        any_hit = cpu.valid && !debug_active && (hit0 || hit1)
               && (!tag_path || cpu.fetch);
        wsel_addr = st.aw_held ? st.aw_addr : s_axi_awaddr;
        rsel_addr = s_axi_araddr;
        // unmapped words read as zero and answer with an error
        rbyte = 8'h00;
        if (is_reg(rsel_addr, OFF_CTL0)) begin
            rbyte = st.ctl0;
        end
        if (is_reg(rsel_addr, OFF_CTL1)) begin
            rbyte = st.ctl1 & CTL1_RD_MASK;
        end
        if (is_reg(rsel_addr, OFF_ADDR_HI)) begin
            rbyte = st.addr_compare_high;
        end
        if (is_reg(rsel_addr, OFF_ADDR_LO)) begin
            rbyte = st.addr_compare_low;
        end
        if (is_reg(rsel_addr, OFF_SEC_HI)) begin
            rbyte = st.second_compare_high;
        end
        if (is_reg(rsel_addr, OFF_SEC_LO)) begin
            rbyte = st.second_compare_low;
        end
        if (is_reg(rsel_addr, OFF_STATUS)) begin
            rbyte = {5'h00, dual, st.hit_seen};
        end
        rword = {24'h00_0000, rbyte};
    end

    logic aw_take;
    logic w_take;
    logic do_write;
    logic strb_ok;
    logic [7:0] wb;

    always_comb begin
        next_st = st;
        aw_take = s_axi_awvalid && st.awready;
        w_take = s_axi_wvalid && st.wready;
        if (aw_take) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
            next_st.awready = 1'b0;
        end
        if (w_take) begin
            next_st.w_held = 1'b1;
            next_st.w_byte = s_axi_wdata[7:0];
            next_st.w_lane0 = s_axi_wstrb[0];
            next_st.wready = 1'b0;
        end
        do_write = (st.aw_held || aw_take) && (st.w_held || w_take) && !st.bvalid;
        wb = w_take ? s_axi_wdata[7:0] : st.w_byte;
        strb_ok = w_take ? s_axi_wstrb[0] : st.w_lane0;
        // only byte lane 0 carries a register; a cleared strobe leaves it alone
        if (do_write && strb_ok) begin
            if (is_reg(wsel_addr, OFF_CTL0)) begin
                next_st.ctl0 = wb;
            end
            if (is_reg(wsel_addr, OFF_CTL1)) begin
                next_st.ctl1 = wb & CTL1_RD_MASK;
            end
            if (is_reg(wsel_addr, OFF_ADDR_HI)) begin
                next_st.addr_compare_high = wb;
            end
            if (is_reg(wsel_addr, OFF_ADDR_LO)) begin
                next_st.addr_compare_low = wb;
            end
            if (is_reg(wsel_addr, OFF_SEC_HI)) begin
                next_st.second_compare_high = wb;
            end
            if (is_reg(wsel_addr, OFF_SEC_LO)) begin
                next_st.second_compare_low = wb;
            end
        end
        if (do_write) begin
            next_st.bresp = map_ok(wsel_addr) ? RESP_OKAY : RESP_SLVERR;
            next_st.bvalid = 1'b1;
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
            next_st.awready = 1'b1;
            next_st.wready = 1'b1;
        end
        if (s_axi_arvalid && st.arready) begin
            next_st.arready = 1'b0;
            next_st.rvalid = 1'b1;
            next_st.rdata = rword;
            next_st.rresp = map_ok(rsel_addr) ? RESP_OKAY : RESP_SLVERR;
        end
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
            next_st.arready = 1'b1;
        end
        // outputs registered: request one cycle after the matching bus cycle
        next_st.brk.swi_req = any_hit && (st.ctl0.mode_sel == MODE_SWI_DUAL);
        next_st.brk.dbg_req = any_hit && st.ctl0.mode_sel[1] && debug_enable
                           && !tag_path;
        next_st.brk.tag_fetch = any_hit && st.ctl0.mode_sel[1] && debug_enable
                             && tag_path;
        // sticky hit record; set wins over the clear by write
        if (do_write && strb_ok && is_reg(wsel_addr, OFF_STATUS)) begin
            next_st.hit_seen = st.hit_seen & ~wb[1:0];
        end
        if (any_hit) begin
            next_st.hit_seen = next_st.hit_seen | {hit1, hit0};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.ctl0 <= RST_BYTE;
            st.ctl1 <= RST_BYTE;
            st.awready <= 1'b1;
            st.wready <= 1'b1;
            st.arready <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign brk = st.brk;
endmodule

// *** rtl/hbc_pkg.sv ***
package hbc_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OFF_CTL0 = 8'h20;
    localparam logic [7:0] OFF_CTL1 = 8'h21;
    localparam logic [7:0] OFF_ADDR_HI = 8'h22;
    localparam logic [7:0] OFF_ADDR_LO = 8'h23;
    localparam logic [7:0] OFF_SEC_HI = 8'h24;
    localparam logic [7:0] OFF_SEC_LO = 8'h25;
    localparam logic [7:0] OFF_STATUS = 8'h28;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] CTL1_RD_MASK = 8'h7f;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [1:0] MODE_OFF = 2'b00;
    localparam logic [1:0] MODE_SWI_DUAL = 2'b01;
    localparam logic [1:0] MODE_FULL = 2'b10;
    localparam logic [1:0] MODE_DBG_DUAL = 2'b11;

    typedef struct packed {
        logic [1:0] mode_sel;
        logic program_only_break;
        logic bp1_low_addr_en;
        logic bp0_low_addr_en;
        logic size_select;
        logic [1:0] spare;
    } hbc_ctl0_t;

    typedef struct packed {
        logic zero;
        logic second_pair_enable;
        logic data_high_mask;
        logic data_low_mask;
        logic bp1_dir_compare_en;
        logic bp1_dir_value;
        logic bp0_dir_compare_en;
        logic bp0_dir_value;
    } hbc_ctl1_t;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic [15:0] data;
        logic rd;
        logic fetch;
    } hbc_cpu_t;

    typedef struct packed {
        logic swi_req;
        logic dbg_req;
        logic tag_fetch;
    } hbc_brk_t;
endpackage

// *** verif/hbc_break_asserts.sv ***
`timescale 1ns/1ps
module hbc_break_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [hbc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire hbc_pkg::hbc_cpu_t cpu,
    input wire logic debug_enable,
    input wire logic debug_active,
    input wire hbc_pkg::hbc_brk_t brk
);
    import hbc_pkg::*;
    logic [1:0] mode;
    // mirror of the mode field, seen only from writes taken on the bus
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode <= MODE_OFF;
        end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                && s_axi_awaddr[ADDR_W-1:2] == OFF_CTL0[ADDR_W-3:0] && s_axi_wstrb[0]) begin
            mode <= s_axi_wdata[7:6];
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_bresp; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> s_axi_bvalid && !s_axi_awready; endproperty
    a_bresp: assert property (p_bresp) else $error("write answer late");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read answer dropped");
    property p_active; debug_active |=> !brk.swi_req && !brk.dbg_req && !brk.tag_fetch;
    endproperty
    a_active: assert property (p_active) else $error("break while debug active");
    property p_enable; !debug_enable |=> !brk.dbg_req && !brk.tag_fetch; endproperty
    a_enable: assert property (p_enable) else $error("debug entry not enabled");
    property p_swi; brk.swi_req |-> $past(mode) == MODE_SWI_DUAL && $past(cpu.fetch);
    endproperty
    a_swi: assert property (p_swi) else $error("bad software interrupt");
    property p_dbg; brk.dbg_req || brk.tag_fetch |-> $past(mode[1]); endproperty
    a_dbg: assert property (p_dbg) else $error("debug request in wrong mode");
    property p_cycle; brk.swi_req || brk.dbg_req || brk.tag_fetch |-> $past(cpu.valid);
    endproperty
    a_cycle: assert property (p_cycle) else $error("break without bus cycle");
    property p_tag; brk.tag_fetch |-> !brk.dbg_req && $past(cpu.fetch); endproperty
    a_tag: assert property (p_tag) else $error("tag on non fetch");
    c_swi: cover property (brk.swi_req);
    c_dbg: cover property (brk.dbg_req);
    c_tag: cover property (brk.tag_fetch);
endmodule
bind hbc_break hbc_break_asserts hbc_break_asserts_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .cpu(cpu), .debug_enable(debug_enable), .debug_active(debug_active), .brk(brk));

// *** verif/hbc_cpu_model.sv ***
`timescale 1ns/1ps
module hbc_cpu_model (
    input wire logic aclk,
    input wire hbc_pkg::hbc_brk_t brk,
    output hbc_pkg::hbc_cpu_t cpu,
    output logic debug_enable,
    output logic debug_active
);
    import hbc_pkg::*;
    initial begin
        cpu = '0;
        debug_enable = 1'b0;
        debug_active = 1'b0;
    end
    task automatic cyc(input logic [15:0] a, input logic [15:0] d, input logic rw,
            input logic f, input logic en, input logic act, output hbc_brk_t b);
        @(posedge aclk);
        cpu <= '{1'b1, a, d, rw, f};
        debug_enable <= en;
        debug_active <= act;
        @(posedge aclk);
        // idle bus shows inverted lines so a stale value cannot match by luck
        cpu <= '{1'b0, ~a, ~d, ~rw, ~f};
        @(posedge aclk);
        b = brk;
    endtask
endmodule

// *** verif/tb.sv ***
`timescale 1ns/1ps
module tb;
    import hbc_pkg::*;
    typedef struct packed {
        logic [7:0] c0;
        logic [7:0] c1;
        logic [15:0] a;
        logic [15:0] d;
        logic rw;
        logic f;
        logic en;
        logic act;
        logic [2:0] e;
    } hbc_step_t;
    hbc_step_t steps [21] = '{
        '{8'h88, 8'h00, 16'h1234, 16'h0000, 1, 0, 1, 0, 3'b010},
        '{8'h88, 8'h00, 16'h12ff, 16'h0000, 1, 0, 1, 0, 3'b000},
        '{8'h80, 8'h00, 16'h12ff, 16'h0000, 1, 0, 1, 0, 3'b010},
        '{8'h80, 8'h00, 16'h13ff, 16'h0000, 1, 0, 1, 0, 3'b000},
        '{8'h80, 8'h00, 16'h12ff, 16'h0000, 1, 0, 0, 0, 3'b000},
        '{8'h80, 8'h00, 16'h12ff, 16'h0000, 1, 0, 1, 1, 3'b000},
        '{8'h80, 8'h40, 16'h1200, 16'habcd, 1, 0, 1, 0, 3'b010},
        '{8'h80, 8'h40, 16'h1200, 16'habce, 1, 0, 1, 0, 3'b000},
        '{8'h80, 8'h50, 16'h1200, 16'habce, 1, 0, 1, 0, 3'b010},
        '{8'h80, 8'h60, 16'h1200, 16'hbbcd, 1, 0, 1, 0, 3'b010},
        '{8'h80, 8'h03, 16'h1200, 16'h0000, 0, 0, 1, 0, 3'b000},
        '{8'h80, 8'h03, 16'h1200, 16'h0000, 1, 0, 1, 0, 3'b010},
        '{8'hdc, 8'h4c, 16'habcd, 16'h0000, 1, 0, 1, 0, 3'b010},
        '{8'hdc, 8'h4c, 16'habcd, 16'h0000, 0, 0, 1, 0, 3'b000},
        '{8'hdc, 8'h4c, 16'habcc, 16'h0000, 1, 0, 1, 0, 3'b000},
        '{8'hdc, 8'h0c, 16'habcd, 16'h0000, 1, 0, 1, 0, 3'b000},
        '{8'h58, 8'h43, 16'h1234, 16'h0000, 0, 1, 0, 0, 3'b100},
        '{8'h58, 8'h43, 16'h1234, 16'h0000, 1, 0, 1, 0, 3'b000},
        '{8'ha8, 8'h00, 16'h1234, 16'h0000, 1, 1, 1, 0, 3'b001},
        '{8'ha8, 8'h00, 16'h1234, 16'h0000, 1, 0, 1, 0, 3'b000},
        '{8'h28, 8'h00, 16'h1234, 16'h0000, 1, 1, 1, 0, 3'b000}};
    logic aclk = 0;
    logic aresetn = 0;
    logic [7:0] awaddr = '0;
    logic [7:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, e2, wresp;
    logic [3:0] wstrb = 4'h1;
    logic [31:0] rdata, got;
    hbc_cpu_t cpu;
    hbc_brk_t brk, b;
    logic debug_enable, debug_active;
    int errors = 0, samples_checked = 0, cycles = 0;
    always #2.5 aclk = ~aclk;
    hbc_break hbc_break_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .cpu(cpu), .debug_enable(debug_enable),
        .debug_active(debug_active), .brk(brk));
    hbc_cpu_model hbc_cpu_model_i (.aclk(aclk), .brk(brk), .cpu(cpu),
        .debug_enable(debug_enable), .debug_active(debug_active));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // each register sits alone in an aligned word at four times its index
    function automatic logic [7:0] ba(input logic [7:0] idx);
        ba = {idx[5:0], 2'b00};
    endfunction
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (bvalid !== 1'b1);
        wresp = bresp;
        bready <= 0;
    endtask
    task automatic r(input logic [7:0] a, output logic [31:0] d, output logic [1:0] e);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end while (rvalid !== 1'b1);
        d = rdata;
        e = rresp;
        rready <= 0;
    endtask
    task print_verdict;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ceiling well above the few hundred cycles the sequence needs
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            print_verdict();
        end
    end
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        r(ba(OFF_CTL0), got, e2);
        check(got, 32'h00000000);
        r(ba(OFF_CTL1), got, e2);
        check(got, 32'h00000000);
        w(ba(OFF_CTL0), 8'h88);
        w(ba(OFF_CTL1), 8'hff);
        w(ba(OFF_ADDR_HI), 8'h12);
        w(ba(OFF_ADDR_LO), 8'h34);
        w(ba(OFF_SEC_HI), 8'hab);
        w(ba(OFF_SEC_LO), 8'hcd);
        check({30'h0, wresp}, {30'h0, RESP_OKAY});
        r(ba(OFF_CTL0), got, e2);
        check(got, 32'h00000088);
        r(ba(OFF_CTL1), got, e2);
        check(got, 32'h0000007f);
        r(ba(OFF_ADDR_HI), got, e2);
        check(got, 32'h00000012);
        r(ba(OFF_ADDR_LO), got, e2);
        check(got, 32'h00000034);
        r(ba(OFF_SEC_HI), got, e2);
        check(got, 32'h000000ab);
        r(ba(OFF_SEC_LO), got, e2);
        check(got, 32'h000000cd);
        wstrb <= 4'h0;
        w(ba(OFF_ADDR_HI), 8'hee);
        wstrb <= 4'h1;
        r(ba(OFF_ADDR_HI), got, e2);
        check(got, 32'h00000012);
        w(8'h2c, 8'hff);
        check({30'h0, wresp}, {30'h0, RESP_SLVERR});
        r(8'h2c, got, e2);
        check({30'h0, e2}, {30'h0, RESP_SLVERR});
        $display("register test done");
        foreach (steps[i]) begin
            w(ba(OFF_CTL0), steps[i].c0);
            w(ba(OFF_CTL1), steps[i].c1);
            hbc_cpu_model_i.cyc(steps[i].a, steps[i].d, steps[i].rw, steps[i].f,
                steps[i].en, steps[i].act, b);
            check({29'h0, b}, {29'h0, steps[i].e});
            $display("break step %0d done", i);
        end
        r(ba(OFF_STATUS), got, e2);
        check(got, 32'h00000003);
        w(ba(OFF_STATUS), 8'h03);
        r(ba(OFF_STATUS), got, e2);
        check(got, 32'h00000000);
        $display("status test done");
        print_verdict();
    end
endmodule
